// >>> rtl/sync_presettable_counter_4bit.sv
// module: apb wrapped presettable counter with cascade pins
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
// Function
// RULE1: hold four-bit count on outputs
// RULE2: update all bits on rising edge
// RULE3: clock bits together, no ripple glitches
// RULE4: accept any preset value zero to fifteen
// RULE5: low load copies preset at edge
// RULE6: low clear zeroes count at edge
// RULE7: increment only when both enables high
// RULE8: wrap from fifteen back to zero
// RULE9: carry high at fifteen with trickle high
// RULE10: trickle gates carry combinationally
// RULE11: cascade carry into next stage enables
// RULE12: control changes act only at edge
// RULE13: enables may change at any level
// RULE14: decode count to clear for shorter length; here clear is only the software control bit, no count decode drives it
// RULE15: clear beats load, load beats count
// RULE16: otherwise hold count across edge
module sync_presettable_counter_4bit
    import counter_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // cascade input from a preceding stage (same clock)
    input  wire logic        TRICKLE_COUNT_ENABLE_I,
    // count and carry pins
    output logic      [3:0]  COUNT_O,
    output logic             COUNT_OUT_LSB_O,
    output logic             TERMINAL_CARRY_OUT_O
);
    logic [7:0]  ctrl;        // software control register
    logic [7:0]  next_ctrl;   // next control value
    logic [31:0] rdata;       // read data register
    logic [31:0] next_rdata;  // next read data
    count_ctrl_t core_ctrl;   // control word to core
    count_stat_t core_stat;   // core state
    logic        access;      // apb access phase
    logic        hit_ctrl;    // address hits control
    logic        hit_stat;    // address hits status

    // decode: zero wait, each register one aligned word
    always_comb begin
        access   = PSEL_I && PENABLE_I;
        hit_ctrl = (PADDR_I == CTRL_OFFSET);
        hit_stat = (PADDR_I == STAT_OFFSET);
        PREADY_O = 1'b1;
    end

    // control word: software enable and trickle pin both feed the trickle term,
    // so a cascaded stage counts only when its predecessor carries
    always_comb begin
        core_ctrl.preset_data           = ctrl[CTRL_DAT_LSB +: COUNT_W];
        core_ctrl.sync_load_n           = ctrl[CTRL_LD_BIT];
        core_ctrl.sync_clear_n          = ctrl[CTRL_CLR_BIT];
        core_ctrl.parallel_count_enable = ctrl[CTRL_PAR_BIT];
        core_ctrl.trickle_count_enable  = ctrl[CTRL_TRK_BIT] && TRICKLE_COUNT_ENABLE_I; // RULE11 RULE13
    end

    // next register state; only byte lane 0 holds control bits
    always_comb begin
        next_ctrl   = ctrl;
        next_rdata  = rdata;
        if (access && PWRITE_I) begin
            if (hit_ctrl) begin
                if (PSTRB_I[0]) begin
                    next_ctrl = PWDATA_I[7:0];
                end
            end
            // unmapped or status writes change nothing; the error is combinational
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            // capture read data in setup so it stands in the access cycle
            if (hit_ctrl) begin
                next_rdata = {24'h000000, ctrl};
            end else if (hit_stat) begin
                next_rdata = {27'h0000000, core_stat.terminal_carry_out, core_stat.count};
            end else begin
                next_rdata = 32'h00000000;
            end
        end
    end

    // register state; clear and load stay software levels, so a user must
    // release them to resume counting (they are not self clearing)
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctrl   <= CTRL_RESET;
            rdata  <= 32'h00000000;
        end else begin
            ctrl   <= next_ctrl;
            rdata  <= next_rdata;
        end
    end

    // counting core
    count_core u_core (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .ctrl_i  (core_ctrl),
        .stat_o  (core_stat)
    );

    // outputs; slverr is combinational in the access phase
    always_comb begin
        PRDATA_O             = rdata;
        PSLVERR_O            = access && !hit_ctrl && !hit_stat;
        COUNT_O              = core_stat.count; // RULE1
        COUNT_OUT_LSB_O      = core_stat.count[0];
        TERMINAL_CARRY_OUT_O = core_stat.terminal_carry_out; // RULE9 RULE10
    end
endmodule

// >>> rtl/counter_pkg.sv
// package: widths, offsets, field positions and reset values for the presettable counter
package counter_pkg;
    // count geometry
    localparam int          COUNT_W      = 4;
    localparam logic [3:0]  COUNT_MAX    = 4'hF;
    localparam logic [3:0]  COUNT_ZERO   = 4'h0;
    localparam logic [3:0]  COUNT_STEP   = 4'h1;
    // apb register byte offsets
    localparam logic [11:0] CTRL_OFFSET  = 12'h000;
    localparam logic [11:0] STAT_OFFSET  = 12'h004;
    // control register field positions
    localparam int          CTRL_PAR_BIT = 0;
    localparam int          CTRL_TRK_BIT = 1;
    localparam int          CTRL_CLR_BIT = 2;
    localparam int          CTRL_LD_BIT  = 3;
    localparam int          CTRL_DAT_LSB = 4;
    // status register field positions
    localparam int          STAT_CNT_LSB = 0;
    localparam int          STAT_CRY_BIT = 4;
    // control reset value: enables low, clear and load released, preset zero
    localparam logic [7:0]  CTRL_RESET   = 8'h0C;

    // control word driven into the counting core
    typedef struct packed {
        logic [3:0] preset_data;
        logic       sync_load_n;
        logic       sync_clear_n;
        logic       trickle_count_enable;
        logic       parallel_count_enable;
    } count_ctrl_t;

    // state reported back out of the core
    typedef struct packed {
        logic       terminal_carry_out;
        logic [3:0] count;
    } count_stat_t;

    // next count from control word and present count
    function automatic logic [3:0] next_count_f(input count_ctrl_t c, input logic [3:0] q);
        logic [3:0] r;
        r = q;
        if (!c.sync_clear_n) begin
            r = COUNT_ZERO;
        end else if (!c.sync_load_n) begin
            r = c.preset_data;
        end else if (c.parallel_count_enable && c.trickle_count_enable) begin
            r = q + COUNT_STEP;
        end
        return r;
    endfunction
endpackage

// >>> rtl/count_core.sv
// module: four-bit synchronous counting core with look-ahead carry
`timescale 1ns/1ns
module count_core
    import counter_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // control word
    input  wire count_ctrl_t ctrl_i,
    // state out
    output count_stat_t      stat_o
);
    logic [3:0] count;       // stored count
    logic [3:0] next_count;  // value taken at next edge

    // next count: clear over load over counting, else hold
    always_comb begin
        next_count = next_count_f(ctrl_i, count); // RULE4 RULE5 RULE6 RULE7 RULE8 RULE15 RULE16
    end

    // all four bits registered together on the rising edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= COUNT_ZERO;
        end else begin
            count <= next_count; // RULE2 RULE3 RULE12
        end
    end

    // carry is combinational so a trickle change reaches it without a clock
    always_comb begin
        stat_o.count              = count; // RULE1
        stat_o.terminal_carry_out = (count == COUNT_MAX) && ctrl_i.trickle_count_enable; // RULE9 RULE10
    end
endmodule

// >>> dv/counter_monitor.sv
// checker: port relations of the apb counter
`timescale 1ns/1ns
module counter_monitor
    import counter_pkg::*;
(
    // clock and reset
    input wire logic        CLK_I,
    input wire logic        RST_B_I,
    // apb
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0]  PSTRB_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    // counter pins
    input wire logic        TRICKLE_COUNT_ENABLE_I,
    input wire logic [3:0]  COUNT_O,
    input wire logic        COUNT_OUT_LSB_O,
    input wire logic        TERMINAL_CARRY_OUT_O
);
    logic [7:0] c;      // shadow control, rebuilt from seen writes
    logic [7:0] next_c; // next shadow
    logic       go;     // both count enables high
    // the shadow moves on the same edge as the real control word
    always_comb next_c = (PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0]
        && PADDR_I == CTRL_OFFSET) ? PWDATA_I[7:0] : c;
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) c <= CTRL_RESET;
        else c <= next_c;
    end
    assign go = c[0] && c[1] && TRICKLE_COUNT_ENABLE_I;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // read setup of the status word
    sequence rd_stat;
        PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == STAT_OFFSET;
    endsequence
    lsb_pin_copy_a: assert property (COUNT_OUT_LSB_O == COUNT_O[0])
        else $error("lsb pin");
    carry_gate_a: assert property (TERMINAL_CARRY_OUT_O ==
        (COUNT_O == COUNT_MAX && c[1] && TRICKLE_COUNT_ENABLE_I)) else $error("carry");
    clear_zero_a: assert property (!c[2] |=> COUNT_O == COUNT_ZERO)
        else $error("clear");
    load_copy_a: assert property (c[2] && !c[3] |=> COUNT_O == $past(c[7:4]))
        else $error("load");
    count_step_a: assert property (c[3:2] == 2'h3 && go
        |=> COUNT_O == $past(COUNT_O) + COUNT_STEP) else $error("step");
    count_hold_a: assert property (c[3:2] == 2'h3 && !go |=> $stable(COUNT_O))
        else $error("hold");
    slave_err_a: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O ==
        (PADDR_I != CTRL_OFFSET && PADDR_I != STAT_OFFSET) && PREADY_O) else $error("apb");
    stat_read_a: assert property (rd_stat |=> PRDATA_O ==
        {27'h0, $past(TERMINAL_CARRY_OUT_O), $past(COUNT_O)}) else $error("status");
endmodule
bind sync_presettable_counter_4bit counter_monitor counter_monitor_i (.CLK_I, .RST_B_I,
    .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PSTRB_I, .PRDATA_O, .PREADY_O,
    .PSLVERR_O, .TRICKLE_COUNT_ENABLE_I, .COUNT_O, .COUNT_OUT_LSB_O, .TERMINAL_CARRY_OUT_O);

// >>> dv/cascade_stage.sv
// partner: preceding stage whose carry feeds the trickle pin
`timescale 1ns/1ns
module cascade_stage (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // bench command, carry out
    input  wire logic en_i,
    output logic      carry_o
);
    logic next_carry; // registered, unlike the combinational carry of count_core
    always_comb next_carry = en_i;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) carry_o <= 1'b0;
        else carry_o <= next_carry;
    end
endmodule

// >>> dv/sync_presettable_counter_4bit_bench.sv
// bench: apb scenarios for the presettable counter
`timescale 1ns/1ns
module sync_presettable_counter_4bit_bench
    import counter_pkg::*;
;
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        up_en = 1'b1, pready, pslverr, te, carry, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  count;
    int          num_errors = 0, checks_done = 0;
    initial forever #50 clk = ~clk;
    sync_presettable_counter_4bit sync_presettable_counter_4bit_i (
        .CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .TRICKLE_COUNT_ENABLE_I(te), .COUNT_O(count), .COUNT_OUT_LSB_O(),
        .TERMINAL_CARRY_OUT_O(carry));
    cascade_stage cascade_stage_i (.clk_i(clk), .rst_b_i(rst_b), .en_i(up_en), .carry_o(te));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one apb transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        end_of_test;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, STAT_OFFSET, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk({rd, err}, 33'h1);
        $display("register access done");
        apb(1'b1, CTRL_OFFSET, 32'h57);
        apb(1'b0, STAT_OFFSET, 32'h0);
        chk(rd, 32'h5);
        apb(1'b1, CTRL_OFFSET, 32'hC3);
        apb(1'b0, STAT_OFFSET, 32'h0);
        chk(rd, 32'h0);
        $display("clear and load done");
        apb(1'b1, CTRL_OFFSET, 32'hC4);
        apb(1'b1, CTRL_OFFSET, 32'hCF);
        for (int k = 13; k < 19; k++) begin
            @(posedge clk);
            #1;
            chk({count, carry}, {k[3:0], k == 15});
        end
        $display("count wrap done");
        apb(1'b1, CTRL_OFFSET, 32'hF6);
        apb(1'b0, STAT_OFFSET, 32'h0);
        chk(rd, 32'h1F);
        up_en <= 1'b0;
        @(posedge clk);
        #1;
        chk({count, carry}, 5'h1E);
        apb(1'b1, CTRL_OFFSET, 32'hFF);
        repeat (3) @(posedge clk);
        #1;
        chk(count, 32'hF);
        $display("inhibit done");
        end_of_test;
    end
endmodule
